// ===== dv/bee_evaluator_assertions.sv
`timescale 1ns/1ps
module bee_evaluator_assertions #(
  parameter TICK_CYCLES = 4
)(
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [1:0] cmd_op,
  input wire [8:0] cmd_addr,
  input wire [15:0] cmd_data,
  input wire [127:0] status_operand,
  input wire [63:0] output_flag,
  input wire syntax_err,
  input wire [8:0] err_entry,
  input wire pass_done,
  input wire running
);
  // ****
  // edit length counter
  // ****
  wire take = clk_en & cmd_valid & cmd_ready;
  wire edit = take & (cmd_op == 2'h1 || cmd_op == 2'h2);
  reg [9:0] busy;
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      busy <= 10'h000;
    else if (edit)
      busy <= 10'h200 - {1'b0, cmd_addr};
    else if (clk_en && busy != 10'h000)
      busy <= busy - 10'h001;
  // ****
  // properties
  // ****
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_edit_busy_len: assert property (cmd_ready == (busy == 10'h000)) else $error("ready wrong");
  a_cmd_aborts_run: assert property (take |=> !running) else $error("run kept");
  a_write_no_stall: assert property (take && cmd_op == 2'h0 |=> cmd_ready) else $error("write stall");
  a_compile_ends: assert property (
    cmd_ready && !running && !syntax_err && !take |-> ##[1:514] (running || syntax_err || take)) else $error("hung");
  a_freeze_holds: assert property (!clk_en |=> $stable(output_flag) && $stable(running)
    && $stable(pass_done) && $stable(syntax_err) && $stable(cmd_ready)) else $error("moved while frozen");
  a_run_persists: assert property (running && !take |=> running) else $error("run dropped");
  a_run_ready: assert property (running |-> cmd_ready) else $error("not ready");
  a_err_halts_run: assert property (syntax_err |-> !running && !pass_done) else $error("pass in error");
  a_err_holds: assert property (syntax_err && !take |=> syntax_err && $stable(err_entry)) else $error("err lost");
  a_err_freezes_flag: assert property (syntax_err |=> $stable(output_flag)) else $error("flag moved");
endmodule

bind bee_evaluator bee_evaluator_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .status_operand(status_operand),
  .output_flag(output_flag), .syntax_err(syntax_err), .err_entry(err_entry), .pass_done(pass_done),
  .running(running)
);

// ===== dv/tb_bee_evaluator.sv
`timescale 1ns/1ps
module tb_bee_evaluator;
  typedef struct {
    logic [1:0] kind;
    logic [6:0] idx;
    logic [8:0] exp;
  } bee_note;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [8:0] cmd_addr = 9'h000;
  logic [15:0] cmd_data = 16'h0000;
  logic [127:0] status_operand = 128'h0;
  wire cmd_ready;
  wire [63:0] output_flag;
  wire syntax_err;
  wire [8:0] err_entry;
  wire pass_done;
  wire running;
  int bad_count = 0;
  int total_checks = 0;
  int pc = 0;
  bee_note notes[$];
  logic [7:0] pulses [0:63];
  logic [8:0] base [0:2];
  logic [31:0] lfsr = 32'h0000_60d3;
  logic [2:0] lt [0:4] = '{3'b011, 3'b001, 3'b110, 3'b011, 3'b100};
  logic a;
  logic b;

  bee_evaluator #(.TICK_CYCLES(10)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .status_operand(status_operand),
    .output_flag(output_flag), .syntax_err(syntax_err), .err_entry(err_entry), .pass_done(pass_done),
    .running(running)
  );

  initial
    forever #4 sys_clk = ~sys_clk;

  // ****
  // helpers
  // ****
  task report_and_stop;
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task give_up;
    bad_count++;
    $display("CHECK FAILED %0t wait timed out", $time);
    report_and_stop;
  endtask

  task check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function logic [31:0] bee_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task note(input logic [1:0] k, input logic [6:0] i, input logic [8:0] e);
    notes.push_back('{k, i, e});
  endtask

  task flush;
    int t;
    t = 0;
    while (notes.size() > 0 && t < 5000)
    begin
      @(negedge sys_clk);
      t++;
    end
    if (t >= 5000)
      give_up;
  endtask

  task wait_pass(input int n);
    int t;
    t = 0;
    repeat (n)
    begin
      @(negedge sys_clk);
      while (!pass_done && t < 5000)
      begin
        @(negedge sys_clk);
        t++;
      end
    end
    if (t >= 5000)
      give_up;
  endtask

  task cmd(input logic [1:0] op, input logic [8:0] ad, input logic [15:0] d);
    int t;
    t = 0;
    @(negedge sys_clk);
    cmd_op = op;
    cmd_addr = ad;
    cmd_data = d;
    cmd_valid = 1'b1;
    while (!cmd_ready && t < 2000)
    begin
      @(negedge sys_clk);
      t++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    if (t >= 2000)
      give_up;
  endtask

  task put(input logic [3:0] op, input logic [7:0] arg);
    cmd(2'h0, pc[8:0], {op, 4'h0, arg});
    pc++;
  endtask

  task err_expect(input logic [8:0] e);
    int t;
    t = 0;
    repeat (2) @(negedge sys_clk);
    while (!syntax_err && t < 2000)
    begin
      @(negedge sys_clk);
      t++;
    end
    if (t >= 2000)
      give_up;
    note(2'h1, 7'h00, 9'h001);
    note(2'h2, 7'h00, e);
    flush;
  endtask

  // ****
  // result monitor
  // ****
  always @(negedge sys_clk)
  begin
    bee_note n;
    if (pass_done)
      for (int i = 0; i < 64; i++)
        pulses[i] = pulses[i] + {7'h00, output_flag[i]};
    if ((pass_done || syntax_err) && notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.kind)
        2'h0: check({8'h00, output_flag[n.idx[5:0]]}, n.exp);
        2'h1: check({8'h00, syntax_err}, n.exp);
        2'h2: check(err_entry, n.exp);
        default: check({1'b0, pulses[n.idx[5:0]]}, n.exp);
      endcase
    end
  end

  // ****
  // main sequence
  // ****
  initial
  begin
    for (int i = 0; i < 64; i++)
      pulses[i] = 8'h00;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    note(2'h0, 7'h00, 9'h000);
    note(2'h1, 7'h00, 9'h000);
    flush;
    for (int g = 0; g < 5; g++)
    begin
      put(4'h1, 8'h00);
      put(4'h1, 8'h01);
      put(4'h3 + g[3:0], 8'h02);
      put(4'hd, g[7:0]);
    end
    put(4'h1, 8'h00);
    put(4'h2, 8'h00);
    put(4'hd, 8'h05);
    for (int i = 0; i < 16; i++)
      put(4'h1, 8'h10 + i[7:0]);
    put(4'h4, 8'h10);
    put(4'hd, 8'h0b);
    put(4'h1, 8'h02);
    put(4'h1, 8'h03);
    put(4'h8, 8'h00);
    put(4'hd, 8'h06);
    for (int k = 0; k < 3; k++)
    begin
      put(4'h1, 8'h04);
      put(4'h9 + k[3:0], k[7:0]);
      put(4'hd, 8'h07 + k[7:0]);
    end
    put(4'h1, 8'h05);
    put(4'hc, 8'h00);
    put(4'hd, 8'h0a);
    put(4'h1, 8'h00);
    put(4'hd, 8'h3f);
    cmd(2'h3, 9'h000, 16'h0028);
    cmd(2'h3, 9'h020, 16'h0014);
    for (int r = 0; r < 8; r++)
    begin
      lfsr = bee_next(lfsr);
      status_operand[1:0] = r[1:0];
      status_operand[31:16] = (r == 7) ? 16'hffff : lfsr[31:16];
      wait_pass(3);
      a = status_operand[0];
      b = status_operand[1];
      note(2'h0, 7'h00, a | b);
      note(2'h0, 7'h01, a & b);
      note(2'h0, 7'h02, !(a | b));
      note(2'h0, 7'h03, !(a & b));
      note(2'h0, 7'h04, a ^ b);
      note(2'h0, 7'h05, !a);
      note(2'h0, 7'h0b, &status_operand[31:16]);
      note(2'h0, 7'h3f, a);
      flush;
    end
    for (int i = 0; i < 5; i++)
    begin
      status_operand[3:2] = lt[i][2:1];
      wait_pass(3);
      note(2'h0, 7'h06, {8'h00, lt[i][0]});
      flush;
    end
    status_operand[3:2] = 2'b01;
    wait_pass(3);
    status_operand[3:2] = 2'b00;
    cmd(2'h3, 9'h000, 16'h0028);
    wait_pass(3);
    note(2'h0, 7'h06, 9'h000);
    flush;
    for (int e = 0; e < 2; e++)
    begin
      for (int k = 0; k < 3; k++)
        base[k] = {1'b0, pulses[7 + k]};
      status_operand[4] = !status_operand[4];
      wait_pass(6);
      note(2'h3, 7'h07, base[0] + (e == 0));
      note(2'h3, 7'h08, base[1] + (e == 1));
      note(2'h3, 7'h09, base[2] + 9'h001);
      flush;
    end
    status_operand[5] = 1'b1;
    wait_pass(2);
    note(2'h0, 7'h0a, 9'h000);
    flush;
    wait_pass(10);
    note(2'h0, 7'h0a, 9'h001);
    flush;
    status_operand[5] = 1'b0;
    wait_pass(1);
    note(2'h0, 7'h0a, 9'h001);
    flush;
    wait_pass(8);
    note(2'h0, 7'h0a, 9'h000);
    flush;
    cmd(2'h1, 9'h000, 16'h0000);
    status_operand[0] = 1'b0;
    wait_pass(3);
    note(2'h0, 7'h05, 9'h000);
    flush;
    cmd(2'h2, 9'h000, 16'h0000);
    wait_pass(3);
    note(2'h0, 7'h05, 9'h001);
    flush;
    cmd(2'h0, pc[8:0], 16'h1000);
    cmd(2'h0, pc[8:0] + 9'h001, 16'hd000);
    err_expect(pc[8:0] + 9'h001);
    cmd(2'h0, pc[8:0], 16'h2000);
    err_expect(pc[8:0]);
    cmd(2'h0, pc[8:0], 16'h0000);
    wait_pass(2);
    note(2'h1, 7'h00, 9'h000);
    flush;
    // seal-in: flag 3e is fed back into its own equation
    cmd(2'h0, 9'h03c, 16'h1006);
    cmd(2'h0, 9'h03b, 16'h10be);
    cmd(2'h0, 9'h03d, 16'h3002);
    cmd(2'h0, 9'h03e, 16'hd03e);
    wait_pass(3);
    note(2'h0, 7'h3e, 9'h000);
    flush;
    status_operand[6] = 1'b1;
    wait_pass(3);
    status_operand[6] = 1'b0;
    wait_pass(3);
    note(2'h0, 7'h3e, 9'h001);
    flush;
    clk_en = 1'b0;
    repeat (20) @(negedge sys_clk);
    clk_en = 1'b1;
    wait_pass(2);
    note(2'h0, 7'h3e, 9'h001);
    flush;
    rst_n = 1'b0;
    @(negedge sys_clk);
    rst_n = 1'b1;
    note(2'h0, 7'h3e, 9'h000);
    note(2'h1, 7'h00, 9'h000);
    flush;
    report_and_stop;
  end
endmodule

// ===== hdl/bee_evaluator.v
`timescale 1ns/1ps
`include "bee_map.vh"
module bee_evaluator #(
  parameter TICK_CYCLES = `BEE_MS_NS / `BEE_CLK_NS
)(
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [1:0] cmd_op,
  input wire [8:0] cmd_addr,
  input wire [15:0] cmd_data,
  input wire [127:0] status_operand,
  output reg [63:0] output_flag,
  output reg syntax_err,
  output reg [8:0] err_entry,
  output reg pass_done,
  output reg running
);

  // ***************************************************
  // state
  // ***************************************************
  localparam ST_EDIT = 2'b00;
  localparam ST_COMPILE = 2'b01;
  localparam ST_EVAL = 2'b10;
  localparam ST_HALT = 2'b11;

  reg [1:0] state;
  reg [15:0] list_mem [0:511];
  reg [8:0] ptr;
  reg [8:0] edit_stop;
  reg [15:0] edit_data;
  reg edit_ins;
  reg [31:0] stk;
  reg [5:0] depth;
  reg [31:0] latch_q;
  reg [31:0] os_prev;
  reg [31:0] used_tmr;
  reg [31:0] used_os;
  reg [63:0] used_flag;
  reg [15:0] tmr_pu [0:31];
  reg [15:0] tmr_do [0:31];
  reg [15:0] tmr_stamp [0:31];
  reg [31:0] tmr_last;
  reg [31:0] tmr_out;
  reg [31:0] tick_cnt;
  reg [15:0] ms_now;
  integer i;

  wire [15:0] cur = list_mem[ptr];
  wire [3:0] op = cur[`BEE_OP_MSB:`BEE_OP_LSB];
  wire [7:0] arg = cur[`BEE_ARG_MSB:0];
  wire [4:0] idx = arg[4:0];
  wire last_entry = (ptr == `BEE_LIST_LAST);

  assign cmd_ready = (state != ST_EDIT);

  // ***************************************************
  // operator decode and result
  // ***************************************************
  reg [5:0] need;
  reg bad;
  reg res;
  reg [31:0] gm;
  reg [31:0] gv;
  reg t_held;
  reg [15:0] t_el;

  always @*
  begin
    need = 6'h00;
    bad = 1'b0;
    res = 1'b0;
    gm = (32'h0000_0001 << arg[4:0]) - 32'h0000_0001;
    gv = stk & gm;
    t_held = (stk[0] == tmr_last[idx]);
    t_el = t_held ? (ms_now - tmr_stamp[idx]) : 16'h0000;
    case (op)
      `BEE_OP_OPND:
        res = arg[7] ? output_flag[arg[5:0]] : status_operand[arg[6:0]];
      `BEE_OP_NOT:
      begin
        need = 6'h01;
        res = ~stk[0];
      end
      `BEE_OP_OR, `BEE_OP_AND, `BEE_OP_NOR, `BEE_OP_NAND:
      begin
        need = {1'b0, arg[4:0]};
        bad = (arg[4:0] < `BEE_GATE_MIN) || (arg[4:0] > `BEE_GATE_MAX) || (arg[7:5] != 3'h0);
        case (op)
          `BEE_OP_OR: res = |gv;
          `BEE_OP_AND: res = (gv == gm);
          `BEE_OP_NOR: res = ~|gv;
          default: res = (gv != gm);
        endcase
      end
      `BEE_OP_XOR:
      begin
        need = 6'h02;
        bad = (arg != 8'h02);
        res = stk[0] ^ stk[1];
      end
      `BEE_OP_LATCH:
      begin
        need = 6'h02;
        res = ~stk[0] & (stk[1] | latch_q[idx]);
      end
      `BEE_OP_POS:
      begin
        need = 6'h01;
        res = stk[0] & ~os_prev[idx];
      end
      `BEE_OP_NEG:
      begin
        need = 6'h01;
        res = ~stk[0] & os_prev[idx];
      end
      `BEE_OP_DUAL:
      begin
        need = 6'h01;
        res = stk[0] ^ os_prev[idx];
      end
      `BEE_OP_TIMER:
      begin
        need = 6'h01;
        // zero delay passes the change through on the same pass
        if (stk[0])
          res = tmr_out[idx] | (t_el >= tmr_pu[idx]);
        else
          res = tmr_out[idx] & (t_el < tmr_do[idx]);
      end
      `BEE_OP_ASSIGN:
        need = 6'h01;
      default:
        bad = 1'b1;
    endcase
  end

  // ***************************************************
  // compile checks
  // ***************************************************
  wire dup = ((op == `BEE_OP_TIMER) && used_tmr[idx]) ||
             ((op == `BEE_OP_ASSIGN) && used_flag[arg[5:0]]) ||
             (((op == `BEE_OP_POS) || (op == `BEE_OP_NEG) || (op == `BEE_OP_DUAL)) && used_os[idx]);
  wire short = (need > depth);
  wire ovf = (depth == `BEE_STACK_MAX) && (need == 6'h00);
  wire comp_err = dup | short | ovf | bad;
  wire [5:0] next_depth = (op == `BEE_OP_ASSIGN) ? 6'h00 : (depth - need + 6'h01);
  wire [31:0] next_stk = (op == `BEE_OP_OPND) ? {stk[30:0], res} :
                         (op == `BEE_OP_ASSIGN) ? 32'h0000_0000 :
                         (((stk >> need) << 1) | {31'h0000_0000, res});

  // ***************************************************
  // millisecond time base
  // ***************************************************
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 32'h0000_0000;
      ms_now <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (tick_cnt >= TICK_CYCLES - 1)
      begin
        tick_cnt <= 32'h0000_0000;
        ms_now <= ms_now + 16'h0001;
      end
      else
        tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // ***************************************************
  // sequencer, editor and evaluator
  // ***************************************************
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_COMPILE;
      for (i = 0; i < 512; i = i + 1)
        list_mem[i] <= `BEE_ENTRY_END;
      for (i = 0; i < 32; i = i + 1)
      begin
        tmr_pu[i] <= 16'h0000;
        tmr_do[i] <= 16'h0000;
        tmr_stamp[i] <= 16'h0000;
      end
      ptr <= 9'h000;
      edit_stop <= 9'h000;
      edit_data <= `BEE_ENTRY_END;
      edit_ins <= 1'b0;
      stk <= 32'h0000_0000;
      depth <= 6'h00;
      latch_q <= 32'h0000_0000;
      os_prev <= 32'h0000_0000;
      used_tmr <= 32'h0000_0000;
      used_os <= 32'h0000_0000;
      used_flag <= 64'h0000_0000_0000_0000;
      tmr_last <= 32'h0000_0000;
      tmr_out <= 32'h0000_0000;
      output_flag <= 64'h0000_0000_0000_0000;
      syntax_err <= 1'b0;
      err_entry <= 9'h000;
      pass_done <= 1'b0;
      running <= 1'b0;
    end
    else if (clk_en)
    begin
      pass_done <= 1'b0;
      if (cmd_valid && cmd_ready)
      begin
        // any new setting restarts compile and clears hold cells
        latch_q <= 32'h0000_0000;
        syntax_err <= 1'b0;
        running <= 1'b0;
        stk <= 32'h0000_0000;
        depth <= 6'h00;
        used_tmr <= 32'h0000_0000;
        used_os <= 32'h0000_0000;
        used_flag <= 64'h0000_0000_0000_0000;
        state <= ST_COMPILE;
        ptr <= 9'h000;
        case (cmd_op)
          `BEE_CMD_WRITE:
            list_mem[cmd_addr] <= cmd_data;
          `BEE_CMD_INSERT:
          begin
            edit_ins <= 1'b1;
            edit_stop <= cmd_addr;
            edit_data <= cmd_data;
            ptr <= `BEE_LIST_LAST;
            state <= ST_EDIT;
          end
          `BEE_CMD_DELETE:
          begin
            edit_ins <= 1'b0;
            ptr <= cmd_addr;
            state <= ST_EDIT;
          end
          default:
            if (cmd_addr[5])
              tmr_do[cmd_addr[4:0]] <= cmd_data;
            else
              tmr_pu[cmd_addr[4:0]] <= cmd_data;
        endcase
      end
      else
      begin
        case (state)
          ST_EDIT:
            // one entry moves per cycle
            if (edit_ins)
            begin
              if (ptr == edit_stop)
              begin
                list_mem[ptr] <= edit_data;
                state <= ST_COMPILE;
                ptr <= 9'h000;
              end
              else
              begin
                list_mem[ptr] <= list_mem[ptr - 9'h001];
                ptr <= ptr - 9'h001;
              end
            end
            else if (last_entry)
            begin
              list_mem[ptr] <= `BEE_ENTRY_END;
              state <= ST_COMPILE;
              ptr <= 9'h000;
            end
            else
            begin
              list_mem[ptr] <= list_mem[ptr + 9'h001];
              ptr <= ptr + 9'h001;
            end
          ST_COMPILE:
            if (op != `BEE_OP_END && comp_err)
            begin
              syntax_err <= 1'b1;
              err_entry <= ptr;
              state <= ST_HALT;
            end
            else if (op == `BEE_OP_END || last_entry)
            begin
              state <= ST_EVAL;
              running <= 1'b1;
              ptr <= 9'h000;
              depth <= 6'h00;
            end
            else
            begin
              depth <= next_depth;
              if (op == `BEE_OP_TIMER)
                used_tmr[idx] <= 1'b1;
              if (op == `BEE_OP_ASSIGN)
                used_flag[arg[5:0]] <= 1'b1;
              if (op == `BEE_OP_POS || op == `BEE_OP_NEG || op == `BEE_OP_DUAL)
                used_os[idx] <= 1'b1;
              ptr <= ptr + 9'h001;
            end
          ST_EVAL:
            if (op == `BEE_OP_END)
            begin
              // back-to-back passes run far above four per power cycle
              pass_done <= 1'b1;
              ptr <= 9'h000;
              stk <= 32'h0000_0000;
            end
            else
            begin
              stk <= next_stk;
              case (op)
                `BEE_OP_LATCH:
                  latch_q[idx] <= res;
                `BEE_OP_POS, `BEE_OP_NEG, `BEE_OP_DUAL:
                  os_prev[idx] <= stk[0];
                `BEE_OP_TIMER:
                begin
                  tmr_out[idx] <= res;
                  if (!t_held)
                  begin
                    tmr_last[idx] <= stk[0];
                    tmr_stamp[idx] <= ms_now;
                  end
                end
                `BEE_OP_ASSIGN:
                  output_flag[arg[5:0]] <= stk[0];
                default:
                  ;
              endcase
              if (last_entry)
              begin
                pass_done <= 1'b1;
                ptr <= 9'h000;
                stk <= 32'h0000_0000;
              end
              else
                ptr <= ptr + 9'h001;
            end
          default:
            ;
        endcase
      end
    end
  end

endmodule

// ===== hdl/bee_map.vh
// Operation
// - passes run in list order and stop at the first end marker
// - rising one-shot fires when its input goes false to true
// - falling one-shot fires when its input goes true to false
// - dual one-shot fires on any change of its input
// - a one-shot output is true for exactly one pass
// - at most 32 one-shot instances exist
// - inverter complements the single preceding value
// - or, and, nor, nand take 2 to 16 preceding values
// - gate truth: or any, and all, nor none, nand not all, xor exactly one
// - exclusive or takes exactly the two preceding values
// - hold cell is reset dominant
// - preceding value is reset, the one before it is set
// - hold cell stays set after set releases until reset
// - 32 timers, each started by the preceding value, output pushed
// - timers have pickup and dropout delays, zero means none
// - output flag assignment stores preceding value into one of 64 flags
// - output flag assignment ends the current equation
// - duplicate timer or output flag assignment is a syntax error
// - parameters are evaluated in the order entered
// - hold cells clear at power-up
// - any new setting recompiles and clears all hold cells
// - editor can insert and delete list entries
// - list has 512 entries defaulting to the end marker
// - whole list is evaluated at least four times per power cycle
`ifndef BEE_MAP_VH
`define BEE_MAP_VH
`define BEE_CLK_NS 8
`define BEE_MS_NS 1000000
`define BEE_OP_MSB 15
`define BEE_OP_LSB 12
`define BEE_ARG_MSB 7
`define BEE_LIST_LAST 9'h1ff
`define BEE_ENTRY_END 16'h0000
`define BEE_STACK_MAX 6'h20
`define BEE_GATE_MIN 5'h02
`define BEE_GATE_MAX 5'h10
`define BEE_OP_END 4'h0
`define BEE_OP_OPND 4'h1
`define BEE_OP_NOT 4'h2
`define BEE_OP_OR 4'h3
`define BEE_OP_AND 4'h4
`define BEE_OP_NOR 4'h5
`define BEE_OP_NAND 4'h6
`define BEE_OP_XOR 4'h7
`define BEE_OP_LATCH 4'h8
`define BEE_OP_POS 4'h9
`define BEE_OP_NEG 4'ha
`define BEE_OP_DUAL 4'hb
`define BEE_OP_TIMER 4'hc
`define BEE_OP_ASSIGN 4'hd
`define BEE_CMD_WRITE 2'h0
`define BEE_CMD_INSERT 2'h1
`define BEE_CMD_DELETE 2'h2
`define BEE_CMD_TIMER 2'h3
`endif
